// ---- rtl/bus_status_regs.svh ----
// Status codes, reset values and counts of the local bus status logic.
// Assumes inclusion by the bus status package and both bus ends.
`ifndef BUS_STATUS_REGS_SVH
`define BUS_STATUS_REGS_SVH

// Status codes {code_or_int_ack, mem_or_io, hi_n, lo_n}
`define CODE_INT_ACK     4'h0
`define CODE_IDLE        4'h3
`define CODE_HALT        4'h4
`define CODE_MEM_READ    4'h5
`define CODE_MEM_WRITE   4'h6
`define CODE_IO_READ     4'h9
`define CODE_IO_WRITE    4'ha

// Field positions inside a status code
`define FLD_CODE_INTA    3
`define FLD_MEM_IO       2
`define FLD_STAT_HI      1
`define FLD_STAT_LO      0

// Reset values of the pins
`define RST_STATUS       4'h3
`define RST_LOCK_N       1'b1

// Default wait states added by the bus controller
`define DEF_WAIT_STATES  4

`endif

// ---- rtl/bus_status_pkg.sv ----
// Types shared by both ends of the local bus status logic.
// Assumes bus_status_regs.svh on the include path.
`include "bus_status_regs.svh"

package bus_status_pkg;

  typedef enum logic [3:0] {
    kind_int_ack   = `CODE_INT_ACK,
    kind_halt      = `CODE_HALT,
    kind_mem_read  = `CODE_MEM_READ,
    kind_mem_write = `CODE_MEM_WRITE,
    kind_io_read   = `CODE_IO_READ,
    kind_io_write  = `CODE_IO_WRITE
  } cycle_kind_t;

  typedef enum logic [2:0] {
    st_idle   = 3'b000,
    st_status = 3'b001,
    st_wait   = 3'b010,
    st_float  = 3'b011,
    st_hold   = 3'b100
  } dev_state_t;

  typedef struct packed {
    dev_state_t state;
    logic       hold_meta;
    logic       hold_sync;
    logic [3:0] status;
    logic       addr_one;
    logic       lock_n;
    logic       lock_cur;
    logic       lock_follow;
    logic       drv_en;
    logic       grant;
    logic       busy;
    logic       done;
  } dev_regs_t;

  typedef struct packed {
    logic       hold_req;
    logic       ready_n;
    logic       in_cycle;
    logic [3:0] wait_cnt;
    logic [3:0] kind;
    logic       halt;
    logic       start;
    logic       owned;
  } ctl_regs_t;

endpackage

// ---- rtl/local_bus_if.sv ----
// Local bus status and control lines between the processor end and the controller end.
// Assumes both ends clocked by the same system clock.
`timescale 1ns/1ps

interface local_bus_if;
  logic cycle_status_hi_n;
  logic cycle_status_lo_n;
  logic mem_or_io;
  logic code_or_int_ack;
  logic address_bit_one;
  logic bus_lock_n;
  logic status_oe;
  logic ready_n;
  logic hold_req;
  logic bus_grant_ack;
  logic lock_wire_n;

  // Floated lock line is held weakly high
  assign lock_wire_n = status_oe ? bus_lock_n : 1'b1;

  modport device (
    output cycle_status_hi_n,
    output cycle_status_lo_n,
    output mem_or_io,
    output code_or_int_ack,
    output address_bit_one,
    output bus_lock_n,
    output status_oe,
    output bus_grant_ack,
    input  ready_n,
    input  hold_req
  );

  modport controller (
    input  cycle_status_hi_n,
    input  cycle_status_lo_n,
    input  mem_or_io,
    input  code_or_int_ack,
    input  address_bit_one,
    input  lock_wire_n,
    input  status_oe,
    input  bus_grant_ack,
    output ready_n,
    output hold_req
  );
endinterface

// ---- rtl/bus_ctrl_end.sv ----
// Controller end: decodes status, adds wait states, ends cycles, requests the bus.
// Assumes the processor end on the same clock through local_bus_if.
`timescale 1ns/1ps
`include "bus_status_regs.svh"

module bus_ctrl_end #(
  parameter int WAIT_STATES = `DEF_WAIT_STATES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  local_bus_if.controller  bus,
  input  wire logic        take_bus_in,
  output logic             bus_owned_out,
  output logic             cycle_start_out,
  output logic [3:0]       cycle_kind_out,
  output logic             halt_not_shutdown_out
);

  // Wait counter is four bits wide
  if (WAIT_STATES < 0 || WAIT_STATES > 15) begin : g_bad_wait
    $error("WAIT_STATES must lie in 0..15");
  end

  localparam logic [3:0] WAIT_LOAD = 4'(WAIT_STATES);

  bus_status_pkg::ctl_regs_t q;
  bus_status_pkg::ctl_regs_t d;

  always_comb begin
    d          = q;
    d.start    = 1'b0;
    d.ready_n  = 1'b1;
    if (!q.in_cycle) begin
      // Both status lines high start nothing
      if (bus.status_oe && !bus.bus_grant_ack &&
          !(bus.cycle_status_hi_n && bus.cycle_status_lo_n)) begin // RQ4
        d.in_cycle = 1'b1;
        d.start    = 1'b1;
        d.wait_cnt = WAIT_LOAD;
        d.kind     = {bus.code_or_int_ack, bus.mem_or_io,
                      bus.cycle_status_hi_n, bus.cycle_status_lo_n};
        d.halt     = bus.address_bit_one; // RQ3
      end
    end else if (q.wait_cnt != 4'h0) begin
      d.wait_cnt = q.wait_cnt - 4'h1;
    end else begin
      // Registered one-cycle end of cycle
      d.ready_n  = 1'b0; // RQ11
      d.in_cycle = 1'b0;
    end
    // Never raise a request while the bus is locked; a request already raised is held
    if (!take_bus_in) begin
      d.hold_req = 1'b0; // RQ14
    end else if (bus.lock_wire_n) begin
      d.hold_req = 1'b1; // RQ9
    end
    d.owned = q.hold_req && bus.bus_grant_ack;
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      q         <= '0;
      q.ready_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bus.ready_n            = q.ready_n;
  assign bus.hold_req           = q.hold_req;
  assign bus_owned_out          = q.owned;
  assign cycle_start_out        = q.start;
  assign cycle_kind_out         = q.kind;
  assign halt_not_shutdown_out  = q.halt;

endmodule // bus_ctrl_end

// ---- rtl/bus_status_ctrl.sv ----
// Processor end: bus cycle status, lock, ready termination and hold handshake.
// Assumes the controller end on the same clock through local_bus_if.
//
// Functional notes
// RQ1 - Low code/inta codes: ack, reserved, idle, halt, memory
// RQ2 - High code/inta codes: I/O read, write, idle
// RQ3 - Address bit one tells halt from shutdown
// RQ4 - Both status lines high start no cycle
// RQ5 - Memory/IO high for memory and halt
// RQ6 - Code/inta has the same timing as memory/IO
// RQ7 - Float memory/IO and code/inta keeping last level
// RQ8 - Lock current and following cycle when needed
// RQ9 - Others never take bus while locked
// RQ10 - Lock floats, held high, during hold
// RQ11 - Cycle extends until ready sampled low
// RQ12 - Ready ignored during hold acknowledge
// RQ13 - Float drivers first, then acknowledge hold
// RQ14 - Release bus when hold request drops
// RQ15 - Synchronise hold request; acknowledge always driven
// RQ16 - Two-flop synchroniser; grant only between cycles
`timescale 1ns/1ps
`include "bus_status_regs.svh"

module bus_status_ctrl (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  local_bus_if.device      bus,
  input  wire logic        cycle_req_in,
  input  wire logic [3:0]  cycle_kind_in,
  input  wire logic        halt_in,
  input  wire logic        lock_prefix_in,
  input  wire logic        exchange_instruction_in,
  input  wire logic        descriptor_access_in,
  output logic             busy_out,
  output logic             cycle_done_out,
  output logic             bus_released_out
);

  bus_status_pkg::dev_regs_t q;
  bus_status_pkg::dev_regs_t d;

  // Cycle codes the processor end may start, in match order
  localparam int         N_CODES = 6;
  localparam logic [3:0] IDLE_CODE = `CODE_IDLE;
  localparam logic [3:0] CYCLE_CODES [N_CODES] = '{
    `CODE_INT_ACK,
    `CODE_HALT,
    `CODE_MEM_READ,
    `CODE_MEM_WRITE,
    `CODE_IO_READ,
    `CODE_IO_WRITE
  };
  localparam logic [3:0] FLD_MAP = (4'h1 << `FLD_CODE_INTA) | (4'h1 << `FLD_MEM_IO) |
                                   (4'h1 << `FLD_STAT_HI) | (4'h1 << `FLD_STAT_LO);

  logic [N_CODES-1:0] kind_hit;
  logic               kind_legal;
  logic               is_int_ack;
  logic               is_io;
  logic               is_mem;
  logic               is_halt;
  logic               is_write;
  logic               is_read;
  logic [3:0]         code_next;
  logic               lock_now;
  logic               hold_allowed;

  // Idle must keep both status lines high
  if (!(IDLE_CODE[`FLD_STAT_HI] && IDLE_CODE[`FLD_STAT_LO])) begin : g_bad_idle
    $error("Idle code must keep both status lines high");
  end

  // Field positions must name four distinct bits of the code
  if (FLD_MAP != 4'hf) begin : g_bad_fld
    $error("Status field positions must be distinct bits");
  end

  // One match per listed code; every other code is refused
  for (genvar g = 0; g < N_CODES; g++) begin : g_kind
    if (CYCLE_CODES[g][`FLD_STAT_HI] && CYCLE_CODES[g][`FLD_STAT_LO]) begin : g_bad_code
      $error("Cycle code must not keep both status lines high");
    end
    assign kind_hit[g] = (cycle_kind_in == CYCLE_CODES[g]); // RQ1 RQ2
  end

  assign kind_legal = |kind_hit;

  // Cycle class of the request
  assign is_int_ack = kind_hit[0];
  assign is_halt    = kind_hit[1];
  assign is_mem     = kind_hit[2] || kind_hit[3];
  assign is_io      = kind_hit[4] || kind_hit[5];
  assign is_read    = kind_hit[2] || kind_hit[4];
  assign is_write   = kind_hit[3] || kind_hit[5];

  // Pin levels built from the class of the cycle
  always_comb begin
    code_next                 = 4'h0;
    code_next[`FLD_CODE_INTA] = is_io; // RQ6
    code_next[`FLD_MEM_IO]    = is_mem || is_halt; // RQ5
    code_next[`FLD_STAT_HI]   = is_write;
    code_next[`FLD_STAT_LO]   = is_read;
  end

  // Automatic and explicit lock sources
  assign lock_now = lock_prefix_in || exchange_instruction_in ||
                    descriptor_access_in ||
                    is_int_ack; // RQ8

  // Grant only between cycles and outside a lock
  assign hold_allowed = q.hold_sync && q.lock_n && !q.lock_follow; // RQ16

  always_comb begin
    d           = q;
    d.hold_meta = bus.hold_req; // RQ15
    d.hold_sync = q.hold_meta; // RQ16
    d.done      = 1'b0;
    unique case (q.state)
      bus_status_pkg::st_idle: begin
        d.status = `CODE_IDLE;
        if (hold_allowed) begin
          // Drivers off one cycle ahead of the acknowledge
          d.drv_en = 1'b0; // RQ13
          d.busy   = 1'b1;
          d.state  = bus_status_pkg::st_float;
        end else if (cycle_req_in && kind_legal) begin
          d.status   = code_next; // RQ1 RQ2 RQ5 RQ6
          d.addr_one = is_halt ? halt_in : 1'b0; // RQ3
          d.lock_cur = lock_now;
          d.lock_n   = !(lock_now || q.lock_follow); // RQ8
          d.busy     = 1'b1;
          d.state    = bus_status_pkg::st_status;
        end
      end
      bus_status_pkg::st_status: begin
        // Status stands for one cycle only
        d.status = `CODE_IDLE; // RQ4
        d.state  = bus_status_pkg::st_wait;
      end
      bus_status_pkg::st_wait: begin
        if (!bus.ready_n) begin
          // Lock carries over into the following cycle
          d.lock_follow = q.lock_cur; // RQ8
          d.lock_n      = !q.lock_cur;
          d.lock_cur    = 1'b0;
          d.done        = 1'b1; // RQ11
          d.busy        = 1'b0;
          d.state       = bus_status_pkg::st_idle;
        end
      end
      bus_status_pkg::st_float: begin
        d.grant = 1'b1; // RQ13
        d.state = bus_status_pkg::st_hold;
      end
      bus_status_pkg::st_hold: begin
        // Ready is not looked at here
        if (!q.hold_sync) begin // RQ12
          d.grant  = 1'b0; // RQ14
          d.drv_en = 1'b1;
          d.busy   = 1'b0;
          d.state  = bus_status_pkg::st_idle;
        end
      end
      default: begin
        d.state       = bus_status_pkg::st_idle;
        d.status      = `CODE_IDLE;
        d.addr_one    = 1'b0;
        d.lock_n      = `RST_LOCK_N;
        d.lock_cur    = 1'b0;
        d.lock_follow = 1'b0;
        d.grant       = 1'b0;
        d.drv_en      = 1'b1;
        d.busy        = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      q.state       <= bus_status_pkg::st_idle;
      q.hold_meta   <= 1'b0;
      q.hold_sync   <= 1'b0;
      q.status      <= `RST_STATUS;
      q.addr_one    <= 1'b0;
      q.lock_n      <= `RST_LOCK_N;
      q.lock_cur    <= 1'b0;
      q.lock_follow <= 1'b0;
      q.drv_en      <= 1'b1;
      q.grant       <= 1'b0;
      q.busy        <= 1'b0;
      q.done        <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Pins keep their last level while floated
  assign bus.code_or_int_ack   = q.status[`FLD_CODE_INTA]; // RQ6 RQ7
  assign bus.mem_or_io         = q.status[`FLD_MEM_IO]; // RQ5 RQ7
  assign bus.cycle_status_hi_n = q.status[`FLD_STAT_HI];
  assign bus.cycle_status_lo_n = q.status[`FLD_STAT_LO];
  assign bus.address_bit_one   = q.addr_one;
  assign bus.bus_lock_n        = q.lock_n;
  assign bus.status_oe         = q.drv_en; // RQ7 RQ10
  assign bus.bus_grant_ack     = q.grant; // RQ15
  assign busy_out              = q.busy;
  assign cycle_done_out        = q.done;
  assign bus_released_out      = q.grant;

endmodule // bus_status_ctrl

// ---- tb/bus_status_chk.sv ----
// Checker on the local bus lines joining both ends.
// Assumes instantiation beside the interface in the bench.
`timescale 1ns/1ps

module bus_status_chk (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic cycle_status_hi_n,
  input wire logic cycle_status_lo_n,
  input wire logic mem_or_io,
  input wire logic code_or_int_ack,
  input wire logic address_bit_one,
  input wire logic bus_lock_n,
  input wire logic status_oe,
  input wire logic hold_req,
  input wire logic bus_grant_ack
);
  logic [3:0] code;
  logic       stat;
  assign code = {code_or_int_ack, mem_or_io, cycle_status_hi_n, cycle_status_lo_n};
  assign stat = status_oe && !(cycle_status_hi_n && cycle_status_lo_n);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  sequence take_back_s;
    !bus_grant_ack && status_oe;
  endsequence
  code_set_a: assert property (status_oe |->
    code inside {4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'ha}) else $error("bad code");
  halt_bit_a: assert property (stat && address_bit_one |->
    code == 4'h4) else $error("bit one off halt");
  one_cycle_a: assert property (stat |=>
    cycle_status_hi_n && cycle_status_lo_n) else $error("status too long");
  int_lock_a: assert property (stat && code == 4'h0 |->
    !bus_lock_n) else $error("ack unlocked");
  frozen_a: assert property (!status_oe && !$past(status_oe) |->
    $stable(mem_or_io) && $stable(code_or_int_ack)) else $error("float moved");
  hold_oe_a: assert property (bus_grant_ack |->
    !status_oe) else $error("driven in hold");
  float_first_a: assert property ($rose(bus_grant_ack) |->
    !$past(status_oe)) else $error("grant before float");
  sync_a: assert property ($rose(bus_grant_ack) |->
    $past(hold_req, 3)) else $error("grant too soon");
  lock_grant_a: assert property (!bus_lock_n && status_oe |=>
    !bus_grant_ack) else $error("grant in lock");
  release_a: assert property ($fell(hold_req) && bus_grant_ack |->
    ##[1:4] take_back_s) else $error("bus not taken back");
endmodule // bus_status_chk

// ---- tb/tb_top.sv ----
// Bench joining both ends, running every cycle kind and a hold.
// Assumes rtl files and the header on the include path.
`timescale 1ns/1ps

module tb_top;
  localparam int W = 2;
  logic       clk_sys_in, reset_in, req, halt, take, busy, done, rel;
  logic       owned, start, hseen;
  logic [2:0] lk;
  logic [3:0] kind, kseen;
  int         err_total, n_checks, i;
  logic [3:0] kinds[8] = '{4'h5, 4'h6, 4'h9, 4'ha, 4'h4, 4'h4, 4'h0, 4'h5};
  logic [2:0] locks[8] = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  local_bus_if bus();
  bus_status_ctrl u_bus_status_ctrl (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .bus(bus), .cycle_req_in(req), .cycle_kind_in(kind), .halt_in(halt),
    .lock_prefix_in(lk[2]), .exchange_instruction_in(lk[1]),
    .descriptor_access_in(lk[0]), .busy_out(busy), .cycle_done_out(done),
    .bus_released_out(rel));
  bus_ctrl_end #(.WAIT_STATES(W)) u_bus_ctrl_end (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .bus(bus), .take_bus_in(take), .bus_owned_out(owned),
    .cycle_start_out(start), .cycle_kind_out(kseen), .halt_not_shutdown_out(hseen));
  bus_status_chk u_bus_status_chk (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .cycle_status_hi_n(bus.cycle_status_hi_n), .cycle_status_lo_n(bus.cycle_status_lo_n),
    .mem_or_io(bus.mem_or_io), .code_or_int_ack(bus.code_or_int_ack),
    .address_bit_one(bus.address_bit_one), .bus_lock_n(bus.bus_lock_n),
    .status_oe(bus.status_oe), .hold_req(bus.hold_req), .bus_grant_ack(bus.bus_grant_ack));

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One cycle of kind k, counted from the taking edge to done
  task automatic run(input logic [3:0] k, input logic h, input logic [2:0] l);
    int n;
    logic s;
    n = 0;
    s = 1'b0;
    @(posedge clk_sys_in);
    req <= 1'b1;
    kind <= k;
    halt <= h;
    lk <= l;
    @(posedge clk_sys_in);
    req <= 1'b0;
    lk <= 3'h0;
    do begin
      @(posedge clk_sys_in);
      #1;
      n++;
      if (start === 1'b1) begin
        s = 1'b1;
        chk(kseen, k);
        chk({3'h0, hseen}, {3'h0, h});
        chk({3'h0, busy}, 4'h1);
      end
    end while (done !== 1'b1 && n < 40);
    chk({3'h0, s}, 4'h1);
    chk({3'h0, busy}, 4'h0);
    chk(n[3:0], 4'(3 + W));
  endtask

  // Idle cycles with no decoded cycle and no grant change
  task automatic quiet(input int c, input logic g);
    repeat (c) begin
      @(posedge clk_sys_in);
      #1;
      chk({2'h0, start, owned}, {3'h0, g});
    end
  endtask

  task automatic wait_grant(input logic v);
    int n;
    n = 0;
    while (rel !== v && n < 30) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    @(posedge clk_sys_in);
    #1;
    chk({2'h0, rel, owned}, {2'h0, v, v});
    chk({3'h0, bus.status_oe}, {3'h0, !v});
  endtask

  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    repeat (3000) @(posedge clk_sys_in);
    err_total++;
    stop_test();
  end

  initial begin
    {reset_in, req, halt, take, lk, kind} = {4'h8, 3'h0, 4'h0};
    err_total = 0;
    n_checks = 0;
    repeat (10) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    for (i = 0; i < 8; i++) begin
      run(kinds[i], i == 4, locks[i]);
    end
    @(posedge clk_sys_in);
    req <= 1'b1;
    kind <= 4'h1;
    @(posedge clk_sys_in);
    req <= 1'b0;
    quiet(6, 1'b0);
    run(4'h0, 1'b0, 3'h0);
    @(posedge clk_sys_in);
    take <= 1'b1;
    quiet(12, 1'b0);
    run(4'h5, 1'b0, 3'h0);
    wait_grant(1'b1);
    @(posedge clk_sys_in);
    req <= 1'b1;
    quiet(6, 1'b1);
    @(posedge clk_sys_in);
    req <= 1'b0;
    take <= 1'b0;
    wait_grant(1'b0);
    run(4'h6, 1'b0, 3'h0);
    stop_test();
  end
endmodule // tb_top
